/* verilog/fp_exception_vectoring.sv */
// Summary of operation
// - unimplemented fp instruction and f-line trap use vector 11, offset 0x02c
// - fp branch/set on unordered condition uses vector 48, offset 0x0c0
// - arithmetic fp exceptions use vectors 49..54 from offset 0x0c4, fixed order
// - unimplemented fp data type uses vector 55, offset 0x0dc
// - word with bits 15..12 equal to f is an f-line opcode
// - implemented f-line opcodes execute with no exception
// - valid fp pattern not done in hardware raises unimplemented fp instruction
// - unmatched f-line opcode raises f-line illegal, vector 11, frame format 0
// - breakpoint acknowledge ended by ack or error ack reports illegal instruction
// - format errors and fp conditional traps are integer-unit, not fp vectors
// - vector address is vector base register plus vector number times four
module fp_exception_vectoring (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	input  wire logic        INSTR_VALID,
	input  wire logic [15:0] INSTR_WORD,
	input  wire logic        FP_IMPLEMENTED,
	input  wire logic        FP_RECOGNIZED,
	input  wire logic        FP_UNSUPP_TYPE,
	input  wire logic        FP_BSUN,
	input  wire logic [5:0]  FP_ARITH_EXC,
	input  wire logic        BKPT_ACK_CYCLE,
	input  wire logic        TRANSFER_ACK,
	input  wire logic        TRANSFER_ERROR_ACK,
	input  wire logic [31:0] VECTOR_BASE_REGISTER,
	input  wire logic        EXC_ACCEPT,
	output logic             EXC_REQ,
	output logic [7:0]       EXC_VECTOR,
	output logic [9:0]       EXC_OFFSET,
	output logic [31:0]      EXC_ADDRESS,
	output logic [3:0]       EXC_FRAME,
	output logic             FLINE_EXEC
);
	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	function automatic logic [9:0] vec_offset(input logic [7:0] v);
		vec_offset = 10'(v) << fp_exc_pkg::VEC_SHIFT;
	endfunction

	fp_exc_pkg::state_t state;
	fp_exc_pkg::state_t next_state;

	wire is_fline   = INSTR_VALID && (INSTR_WORD[15:12] == fp_exc_pkg::FLINE_PATTERN);
	wire is_cache   = INSTR_WORD[11:8] == fp_exc_pkg::CACHE_GROUP;
	wire is_fp_id   = INSTR_WORD[11:9] == fp_exc_pkg::FP_COPROC_ID;
	// fp conditional trap and format errors never come here; the integer unit owns them
	wire fline_impl = is_fline && (is_cache || (is_fp_id && FP_IMPLEMENTED));
	wire fline_unim = is_fline && !fline_impl && is_fp_id && FP_RECOGNIZED;
	wire fline_ill  = is_fline && !fline_impl && !fline_unim;
	wire bkpt_ill   = BKPT_ACK_CYCLE && (TRANSFER_ACK || TRANSFER_ERROR_ACK);

	// ------------------------------------------------------------
	// priority: instruction faults first, then data, then arithmetic
	// ------------------------------------------------------------
	logic [7:0] arith_vec;
	logic       arith_hit;
	always_comb begin
		arith_vec = fp_exc_pkg::VEC_ARITH_BASE;
		arith_hit = 1'b0;
		// highest-numbered wins: signaling_not_a_number outranks the rest, as in fp priority
		for (int i = 0; i < fp_exc_pkg::ARITH_N; i++) begin
			if (FP_ARITH_EXC[i]) begin
				arith_vec = fp_exc_pkg::VEC_ARITH_BASE + 8'(i);
				arith_hit = 1'b1;
			end
		end
	end

	wire any_exc = bkpt_ill || fline_unim || fline_ill || FP_UNSUPP_TYPE || FP_BSUN || arith_hit;
	wire [7:0] sel_vec =
		bkpt_ill       ? fp_exc_pkg::VEC_ILLEGAL :
		(fline_unim || fline_ill) ? fp_exc_pkg::VEC_FLINE :
		FP_UNSUPP_TYPE ? fp_exc_pkg::VEC_UNSUPP_DT :
		FP_BSUN        ? fp_exc_pkg::VEC_BSUN :
		arith_vec;
	wire [3:0] sel_frame =
		(bkpt_ill || fline_ill) ? fp_exc_pkg::FRAME_FORMAT_0 :
		fline_unim ? fp_exc_pkg::FRAME_FORMAT_2 :
		fp_exc_pkg::FRAME_FORMAT_3;
	wire [31:0] sel_addr = VECTOR_BASE_REGISTER + {22'h0, vec_offset(sel_vec)};

	wire take = (state == fp_exc_pkg::ST_IDLE) && any_exc;
	wire done = (state == fp_exc_pkg::ST_HOLD) && EXC_ACCEPT;

	always_comb begin
		next_state = state;
		case (state)
			fp_exc_pkg::ST_IDLE: if (any_exc) next_state = fp_exc_pkg::ST_HOLD;
			fp_exc_pkg::ST_HOLD: if (EXC_ACCEPT) next_state = fp_exc_pkg::ST_IDLE;
			default:             next_state = fp_exc_pkg::ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	// new events during hold are dropped: the sequencer restarts the instruction
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state       <= fp_exc_pkg::ST_IDLE;
			EXC_REQ     <= 1'b0;
			EXC_VECTOR  <= 8'h00;
			EXC_OFFSET  <= 10'h000;
			EXC_ADDRESS <= 32'h0000_0000;
			EXC_FRAME   <= 4'h0;
			FLINE_EXEC  <= 1'b0;
		end else begin
			state      <= next_state;
			FLINE_EXEC <= fline_impl;
			if (take) begin
				EXC_REQ     <= 1'b1;
				EXC_VECTOR  <= sel_vec;
				EXC_OFFSET  <= vec_offset(sel_vec);
				EXC_ADDRESS <= sel_addr;
				EXC_FRAME   <= sel_frame;
			end else if (done) begin
				EXC_REQ <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	// ------------------------------------------------------------
	// check helpers
	// ------------------------------------------------------------
	// arithmetic events seen with nothing of higher rank beside them
	wire arith_only = !bkpt_ill && !is_fline && !FP_UNSUPP_TYPE && !FP_BSUN;

	// cycles a vector has waited; saturates so a stalled sequencer cannot wrap it
	logic [3:0] hold_cycles;
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			hold_cycles <= 4'h0;
		end else if (EXC_REQ && !EXC_ACCEPT) begin
			if (hold_cycles != 4'hf) begin
				hold_cycles <= hold_cycles + 4'h1;
			end
		end else begin
			hold_cycles <= 4'h0;
		end
	end

	chk_fline_vector: assert property (take && (fline_unim || fline_ill) |=>
		EXC_VECTOR == 8'h0b && EXC_OFFSET == 10'h02c) else $error("f-line vector wrong");
	chk_bsun_vector: assert property (take && FP_BSUN && !bkpt_ill && !is_fline &&
		!FP_UNSUPP_TYPE |=> EXC_VECTOR == 8'h30 && EXC_OFFSET == 10'h0c0)
		else $error("bsun vector wrong");
	chk_arith_range: assert property (EXC_REQ && EXC_VECTOR >= 8'h31 |->
		EXC_VECTOR <= 8'h37 && EXC_OFFSET == {EXC_VECTOR, 2'b00}) else $error("arith range");
	chk_signaling_not_a_number_vector: assert property (take && FP_ARITH_EXC[5] && !FP_BSUN &&
		!FP_UNSUPP_TYPE && !bkpt_ill && !is_fline |=> EXC_VECTOR == 8'h36)
		else $error("signaling_not_a_number vector wrong");
	chk_unsupp_vector: assert property (take && FP_UNSUPP_TYPE && !bkpt_ill && !is_fline
		|=> EXC_VECTOR == 8'h37 && EXC_OFFSET == 10'h0dc) else $error("data type vector");
	chk_fline_decode: assert property (INSTR_VALID && INSTR_WORD[15:12] != 4'hf
		|-> !fline_impl && !fline_unim && !fline_ill) else $error("non f-line decoded");
	chk_impl_quiet: assert property (state == fp_exc_pkg::ST_IDLE && fline_impl &&
		!bkpt_ill && !FP_UNSUPP_TYPE && !FP_BSUN && !arith_hit |=> !EXC_REQ)
		else $error("implemented op trapped");
	chk_illegal_frame: assert property (take && fline_ill && !bkpt_ill |=>
		EXC_FRAME == 4'h0 && EXC_VECTOR == 8'h0b) else $error("f-line illegal frame");
	chk_bkpt_illegal: assert property (take && bkpt_ill |=> EXC_VECTOR == 8'h04)
		else $error("breakpoint ack not illegal");
	chk_vector_addr: assert property (take |=>
		EXC_ADDRESS == $past(VECTOR_BASE_REGISTER) + {22'h0, EXC_VECTOR, 2'b00})
		else $error("vector address wrong");
	chk_hold_stable: assert property (EXC_REQ && !EXC_ACCEPT |=>
		EXC_REQ && $stable(EXC_VECTOR) && $stable(EXC_ADDRESS)) else $error("vector moved");
	chk_accept_drop: assert property (EXC_REQ && EXC_ACCEPT |=> !EXC_REQ)
		else $error("request not dropped");

	chk_inex_vector: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h01 |=>
		EXC_VECTOR == 8'h31 && EXC_OFFSET == 10'h0c4)
		else $error("inexact vector wrong");
	chk_div0_vector: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h02 |=>
		EXC_VECTOR == 8'h32 && EXC_OFFSET == 10'h0c8)
		else $error("divide by zero vector wrong");
	chk_unfl_vector: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h04 |=>
		EXC_VECTOR == 8'h33 && EXC_OFFSET == 10'h0cc)
		else $error("underflow vector wrong");
	chk_operr_vector: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h08 |=>
		EXC_VECTOR == 8'h34 && EXC_OFFSET == 10'h0d0)
		else $error("operand error vector wrong");
	chk_ovfl_vector: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h10 |=>
		EXC_VECTOR == 8'h35 && EXC_OFFSET == 10'h0d4)
		else $error("overflow vector wrong");
	chk_signaling_not_a_number_only: assert property (
		take && arith_only && FP_ARITH_EXC == 6'h20 |=>
		EXC_VECTOR == 8'h36 && EXC_OFFSET == 10'h0d8)
		else $error("signaling_not_a_number alone vector wrong");
	chk_ovfl_rank: assert property (
		take && arith_only && FP_ARITH_EXC[fp_exc_pkg::ARITH_OVFL] &&
		!FP_ARITH_EXC[fp_exc_pkg::ARITH_SIGNALING_NOT_A_NUMBER] |=> EXC_VECTOR == 8'h35)
		else $error("overflow rank wrong");
	chk_operr_rank: assert property (
		take && arith_only && FP_ARITH_EXC[fp_exc_pkg::ARITH_OPER] &&
		FP_ARITH_EXC[5:4] == 2'b00 |=> EXC_VECTOR == 8'h34)
		else $error("operand error rank wrong");
	chk_unsupp_over_arith: assert property (
		take && FP_UNSUPP_TYPE && arith_hit && !bkpt_ill && !is_fline |=>
		EXC_VECTOR == 8'h37)
		else $error("data type lost to arithmetic");
	chk_bsun_over_arith: assert property (
		take && FP_BSUN && arith_hit && !FP_UNSUPP_TYPE && !bkpt_ill && !is_fline |=>
		EXC_VECTOR == 8'h30)
		else $error("bsun lost to arithmetic");
	chk_unimpl_frame: assert property (
		take && fline_unim && !bkpt_ill |=>
		EXC_VECTOR == 8'h0b && EXC_FRAME == 4'h2)
		else $error("unimplemented fp frame wrong");
	chk_unimpl_needs: assert property (
		take && fline_unim |->
		FP_RECOGNIZED && !FP_IMPLEMENTED && INSTR_WORD[11:9] == 3'h1)
		else $error("unimplemented without pattern");
	chk_fline_over_data: assert property (
		take && (fline_unim || fline_ill) && FP_UNSUPP_TYPE && !bkpt_ill |=>
		EXC_VECTOR == 8'h0b)
		else $error("f-line lost to data type");
	chk_bkpt_frame: assert property (
		take && bkpt_ill |=>
		EXC_FRAME == 4'h0 && EXC_OFFSET == 10'h010)
		else $error("breakpoint frame wrong");
	chk_bkpt_over_fline: assert property (
		take && bkpt_ill && is_fline |=>
		EXC_VECTOR == 8'h04)
		else $error("breakpoint lost to f-line");
	chk_iu_range: assert property (
		take && bkpt_ill |=>
		EXC_VECTOR < 8'h30)
		else $error("integer-unit fault in fp range");
	chk_zero_base: assert property (
		take && VECTOR_BASE_REGISTER == 32'h0000_0000 |=>
		EXC_ADDRESS == {22'h0, EXC_OFFSET})
		else $error("address with zero base wrong");
	chk_offset_match: assert property (
		EXC_REQ |->
		EXC_OFFSET == {EXC_VECTOR, 2'b00})
		else $error("offset not four times vector");
	chk_frame_legal: assert property (
		EXC_REQ |->
		EXC_FRAME == 4'h0 || EXC_FRAME == 4'h2 || EXC_FRAME == 4'h3)
		else $error("frame format unknown");
	chk_take_raises: assert property (
		take |=>
		EXC_REQ && state == fp_exc_pkg::ST_HOLD)
		else $error("taken fault not raised");
	chk_req_state: assert property (
		EXC_REQ == (state == fp_exc_pkg::ST_HOLD))
		else $error("request and state disagree");
	chk_idle_quiet: assert property (
		!EXC_REQ && !any_exc |=>
		!EXC_REQ)
		else $error("request with no fault");
	chk_hold_frame: assert property (
		EXC_REQ && !EXC_ACCEPT |=>
		$stable(EXC_FRAME) && $stable(EXC_OFFSET))
		else $error("frame moved while held");
	chk_hold_count: assert property (
		hold_cycles != 4'h0 |->
		EXC_REQ)
		else $error("wait count without request");
	chk_accept_idle: assert property (
		EXC_REQ && EXC_ACCEPT |=>
		state == fp_exc_pkg::ST_IDLE)
		else $error("state not idle after accept");
	chk_fexec_set: assert property (
		fline_impl |=>
		FLINE_EXEC)
		else $error("implemented op not flagged");
	chk_fexec_clear: assert property (
		!fline_impl |=>
		!FLINE_EXEC)
		else $error("flag without implemented op");
	chk_cache_impl: assert property (
		is_fline && INSTR_WORD[11:8] == 4'h4 |->
		fline_impl && !fline_ill && !fline_unim)
		else $error("cache push not implemented");
	chk_nonfline_quiet: assert property (
		INSTR_WORD[15:12] != 4'hf |=>
		!FLINE_EXEC)
		else $error("non f-line op flagged");

	cov_fline_illegal: cover property (take && fline_ill);
	cov_unimpl:        cover property (take && fline_unim);
	cov_arith:         cover property (take && arith_hit ##[1:4] EXC_ACCEPT);
	cov_bkpt:          cover property (take && bkpt_ill);
	cov_held_long:     cover property (hold_cycles == 4'h3 ##1 EXC_ACCEPT);
endmodule // fp_exception_vectoring

/* verilog/fp_exc_pkg.sv */
package fp_exc_pkg;
	// ------------------------------------------------------------
	// vector numbers
	// ------------------------------------------------------------
	localparam logic [7:0] VEC_FLINE       = 8'h0b;
	localparam logic [7:0] VEC_ILLEGAL     = 8'h04;
	localparam logic [7:0] VEC_BSUN        = 8'h30;
	localparam logic [7:0] VEC_ARITH_BASE  = 8'h31;
	localparam logic [7:0] VEC_UNSUPP_DT   = 8'h37;
	localparam logic [3:0] FLINE_PATTERN   = 4'hf;
	localparam logic [3:0] FRAME_FORMAT_0  = 4'h0;
	localparam logic [3:0] FRAME_FORMAT_2  = 4'h2;
	localparam logic [3:0] FRAME_FORMAT_3  = 4'h3;
	// coprocessor id field of a floating-point instruction
	localparam logic [2:0] FP_COPROC_ID    = 3'h1;
	// cache push/invalidate group: f4xx
	localparam logic [3:0] CACHE_GROUP     = 4'h4;
	localparam logic [1:0] VEC_SHIFT       = 2'h2;
	// arithmetic exception indices, in vector order
	localparam int ARITH_INEX = 0;
	localparam int ARITH_DZ   = 1;
	localparam int ARITH_UNFL = 2;
	localparam int ARITH_OPER = 3;
	localparam int ARITH_OVFL = 4;
	localparam int ARITH_SIGNALING_NOT_A_NUMBER = 5;
	localparam int ARITH_N    = 6;
	typedef enum logic [1:0] {ST_IDLE, ST_HOLD} state_t;
endpackage

/* test/exc_sequencer_model.sv */
module exc_sequencer_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       exc_req,
	input  wire logic [1:0] lag,
	output logic            exc_accept
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_cnt;
	// a busy sequencer leaves the request standing for lag extra cycles
	assign exc_accept = exc_req && (wait_cnt == lag);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			wait_cnt <= 2'h0;
		else if (exc_req && !exc_accept)
			wait_cnt <= wait_cnt + 2'h1;
		else
			wait_cnt <= 2'h0;
	end
endmodule // exc_sequencer_model

/* test/fp_exception_vectoring_tb.sv */
module fp_exception_vectoring_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_b = 0, valid = 0, impl = 0, recog = 0, unsupp = 0, bsun = 0;
	logic        bkpt = 0, ta = 0, transfer_error_ack = 0, req, accept, fexec;
	logic [15:0] word = 16'h0;
	logic [5:0]  arith = 6'h0;
	logic [31:0] vector_base_register = 32'h0, r, addr;
	logic [1:0]  lag = 2'h0;
	logic [7:0]  vec, hv;
	logic [9:0]  off;
	logic [3:0]  frame;
	logic [43:0] e, expq[$];
	int          miscompares = 0, samples_checked = 0, cycles = 0, seed = 32'h11cc;
	fp_exception_vectoring dut (.SYS_CLK(clk), .RST_B(rst_b), .INSTR_VALID(valid),
		.INSTR_WORD(word), .FP_IMPLEMENTED(impl), .FP_RECOGNIZED(recog),
		.FP_UNSUPP_TYPE(unsupp), .FP_BSUN(bsun), .FP_ARITH_EXC(arith),
		.BKPT_ACK_CYCLE(bkpt), .TRANSFER_ACK(ta), .TRANSFER_ERROR_ACK(transfer_error_ack),
		.VECTOR_BASE_REGISTER(vector_base_register), .EXC_ACCEPT(accept), .EXC_REQ(req), .EXC_VECTOR(vec),
		.EXC_OFFSET(off), .EXC_ADDRESS(addr), .EXC_FRAME(frame), .FLINE_EXEC(fexec));
	exc_sequencer_model seq (.clk(clk), .rst_b(rst_b), .exc_req(req), .lag(lag),
		.exc_accept(accept));
	initial forever #50 clk = ~clk;
	task check(input string what, input logic [43:0] exp, input logic [43:0] got);
		samples_checked++;
		if (exp !== got) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// result watcher: one note per accepted vector
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (rst_b && req === 1'b1 && accept === 1'b1) begin
			if (expq.size() == 0)
				check("spurious", 44'h0, 44'h1);
			else begin
				e = expq.pop_front();
				check("vector", e, {vec, frame, addr});
				check("offset", {34'h0, e[43:36], 2'h0}, {34'h0, off});
			end
		end
		if (cycles > 5000) begin
			miscompares++;
			end_of_test();
		end
	end
	// one event is applied for one cycle; the wait ends once the vector is gone
	task ev(input logic [15:0] w, input logic [7:0] fl, input logic [5:0] ar,
		input logic [7:0] v, input logic [3:0] f, input logic we, input logic wf);
		int n;
		@(posedge clk);
		r = $random(seed);
		lag <= r[1:0];
		vector_base_register <= r;
		word <= w;
		{valid, impl, recog, unsupp, bsun, bkpt, ta, transfer_error_ack} <= fl;
		arith <= ar;
		if (we)
			expq.push_back({v, f, r + {22'h0, v, 2'h0}});
		@(posedge clk);
		{valid, impl, recog, unsupp, bsun, bkpt, ta, transfer_error_ack} <= 8'h0;
		arith <= 6'h0;
		#1 check("fline_exec", {43'h0, wf}, {43'h0, fexec});
		n = 0;
		while ((req === 1'b1 || n < 2) && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		check("accepted", 44'h0, 44'(expq.size()));
	endtask
	initial begin
		@(posedge clk);
		#1 check("reset", 44'h0, {vec, frame, addr});
		check("reset_req", 44'h0, {42'h0, req, fexec});
		@(posedge clk);
		rst_b <= 1'b1;
		for (int k = 0; k < 6; k++)
			ev(16'h0, 8'h00, 6'h1 << k, 8'h31 + 8'(k), 4'h3, 1, 0);
		repeat (4) begin
			r = $random(seed);
			hv = 8'h31;
			for (int k = 1; k < 6; k++)
				if (r[k]) hv = 8'h31 + 8'(k);
			ev(16'h0, 8'h00, r[5:0] | 6'h01, hv, 4'h3, 1, 0);
		end
		$display("test arith done");
		ev(16'h0, 8'h08, 6'h00, 8'h30, 4'h3, 1, 0);
		ev(16'h0, 8'h08, 6'h3f, 8'h30, 4'h3, 1, 0);
		ev(16'h0, 8'h18, 6'h3f, 8'h37, 4'h3, 1, 0);
		ev(16'h0, 8'h06, 6'h00, 8'h04, 4'h0, 1, 0);
		ev(16'h0, 8'h15, 6'h01, 8'h04, 4'h0, 1, 0);
		$display("test events done");
		r = $random(seed);
		ev(16'hf000, 8'h80, 6'h00, 8'h0b, 4'h0, 1, 0);
		ev({8'hf2, r[7:0]}, 8'ha0, 6'h00, 8'h0b, 4'h2, 1, 0);
		ev({8'hf2, r[7:0]}, 8'hc0, 6'h00, 8'h00, 4'h0, 0, 1);
		ev({8'hf4, r[15:8]}, 8'h80, 6'h00, 8'h00, 4'h0, 0, 1);
		ev({1'b0, r[14:0]}, 8'hc0, 6'h00, 8'h00, 4'h0, 0, 0);
		$display("test fline done");
		repeat (3) @(posedge clk);
		end_of_test();
	end
endmodule // fp_exception_vectoring_tb
